// [verilog/scp_chopper.v]
// Purpose : Fixed off-time chopper with synchronous rectification and latched protection.
// Assumes : Comparator levels arrive as asynchronous pins; reset_in is power-on reset.
// Notes   : Analog trip reference is produced by an external converter from the code output.
//
// What this block does
// - Each off period lasts a fixed time counted from the internal clock; only a fault, a short or disable ends it sooner.
// - The off time is one of three levels picked from the present step current ratio.
// - During the off period the off-side switch is turned on for synchronous rectification.
// - A dead time of about 0.5 us separates turning one switch off and its partner on.
// - A sense voltage above the short threshold of about 0.7 V disables both switch outputs.
// - The short fault stays latched until power-on reset.
// - A positive sense voltage seen during an off period flags a coil-open event for it.
// - Coil-open protection engages only after three consecutive off periods with detection.
// - Breakdown shorter than a fixed window is ignored; shutdown needs accumulated time past it.
// - Die temperature above the thermal threshold disables both switch outputs.
// - The trip reference is the external reference scaled by the present step proportion.
// - Sense reaching the trip level resets the drive latch and starts the off period.
// - The current comparator is ignored for a blanking time after each turn-on.
`timescale 1ns/1ps
`include "scp_map.vh"
module scp_chopper #(
   parameter RW        = 8,
   parameter OFF_HIGH  = `SCP_OFF_HIGH_CYC,
   parameter OFF_MID   = `SCP_OFF_MID_CYC,
   parameter OFF_LOW   = `SCP_OFF_LOW_CYC,
   parameter DEAD      = `SCP_DEAD_CYC,
   parameter BLANK     = `SCP_BLANK_CYC,
   parameter OPEN_DLY  = `SCP_OPEN_DELAY_CYC
) (
   input  wire          clk_in,
   input  wire          reset_in,
   input  wire          enable_in,
   input  wire [RW-1:0] step_ratio_in,
   input  wire          trip_cmp_in,
   input  wire          short_cmp_in,
   input  wire          sense_positive_in,
   input  wire          thermal_shutdown_threshold_in,
   output reg           drive_on_out,
   output reg           rectify_on_out,
   output reg  [RW-1:0] trip_current_target_out,
   output reg           short_fault_out,
   output reg           open_fault_out,
   output reg           thermal_fault_out,
   output reg           open_event_out
);
   localparam CW = 16;
   localparam [CW-1:0] C_OFF_H = OFF_HIGH[CW-1:0];
   localparam [CW-1:0] C_OFF_M = OFF_MID[CW-1:0];
   localparam [CW-1:0] C_OFF_L = OFF_LOW[CW-1:0];
   localparam [CW-1:0] C_DEAD  = DEAD[CW-1:0];
   localparam [CW-1:0] C_BLANK = BLANK[CW-1:0];
   localparam [CW-1:0] C_ODLY  = OPEN_DLY[CW-1:0];
   localparam [1:0]    C_OTRIP = `SCP_OPEN_TRIP_COUNT;
   // One-hot states.
   localparam [5:0] S_IDLE  = 6'h01;
   localparam [5:0] S_DEAD1 = 6'h02;
   localparam [5:0] S_BLANK = 6'h04;
   localparam [5:0] S_ON    = 6'h08;
   localparam [5:0] S_DEAD2 = 6'h10;
   localparam [5:0] S_OFF   = 6'h20;

   // ------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------
   wire [3:0] pins_s;
   scp_sync2 #(.W(4)) u_sync (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .d_in     ({trip_cmp_in, short_cmp_in, sense_positive_in,
                  thermal_shutdown_threshold_in}),
      .q_out    (pins_s)
   );
   wire trip_s  = pins_s[3];
   wire short_s = pins_s[2];
   wire pos_s   = pins_s[1];
   wire hot_s   = pins_s[0];

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   reg [5:0]    state_ff;
   reg [5:0]    nxt_state;
   reg [CW-1:0] cnt_ff;
   reg [CW-1:0] nxt_cnt;
   reg [CW-1:0] off_len_ff;
   reg [1:0]    open_run_ff;
   reg [CW-1:0] brk_time_ff;
   reg          seen_pos_ff;
   wire         fault_any = short_fault_out | open_fault_out | thermal_fault_out;
   wire         kill      = fault_any | short_s | hot_s;

   // Off-time level from the ratio of the present step.
   reg [CW-1:0] off_sel;
   always @* begin
      if (step_ratio_in >= `SCP_RATIO_HIGH_MIN)
         off_sel = C_OFF_H;
      else if (step_ratio_in >= `SCP_RATIO_MID_MIN)
         off_sel = C_OFF_M;
      else
         off_sel = C_OFF_L;
   end

   // ------------------------------------------------------------
   // Chopper sequence
   // ------------------------------------------------------------
   always @* begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff + 16'h0001;
      case (state_ff)
         S_IDLE: begin
            nxt_cnt = 16'h0000;
            if (enable_in)
               nxt_state = S_DEAD1;
         end
         S_DEAD1: begin
            if (cnt_ff >= C_DEAD - 16'h0001) begin
               nxt_state = S_BLANK;
               nxt_cnt   = 16'h0000;
            end
         end
         S_BLANK: begin
            if (cnt_ff >= C_BLANK - 16'h0001) begin
               nxt_state = S_ON;
               nxt_cnt   = 16'h0000;
            end
         end
         S_ON: begin
            nxt_cnt = 16'h0000;
            if (trip_s)
               nxt_state = S_DEAD2;
         end
         S_DEAD2: begin
            if (cnt_ff >= C_DEAD - 16'h0001) begin
               nxt_state = S_OFF;
               nxt_cnt   = 16'h0000;
            end
         end
         S_OFF: begin
            // Here the timer ends the off period, or kill or disable below end it sooner; sense has no say.
            if (cnt_ff >= off_len_ff - 16'h0001) begin
               nxt_state = S_DEAD1;
               nxt_cnt   = 16'h0000;
            end
         end
         default: begin
            nxt_state = S_IDLE;
            nxt_cnt   = 16'h0000;
         end
      endcase
      if (kill || !enable_in) begin
         nxt_state = S_IDLE;
         nxt_cnt   = 16'h0000;
      end
   end

   wire off_entry = (state_ff == S_DEAD2) && (nxt_state == S_OFF);
   wire off_exit  = (state_ff == S_OFF) && (nxt_state != S_OFF);

   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_ff                <= S_IDLE;
         cnt_ff                  <= 16'h0000;
         off_len_ff              <= 16'h0001;
         drive_on_out            <= 1'b0;
         rectify_on_out          <= 1'b0;
         trip_current_target_out <= {RW{1'b0}};
      end else begin
         state_ff     <= nxt_state;
         cnt_ff       <= nxt_cnt;
         if (off_entry)
            off_len_ff <= off_sel;
         drive_on_out   <= (nxt_state == S_BLANK) || (nxt_state == S_ON);
         rectify_on_out <= (nxt_state == S_OFF);
         // Converter code follows the step proportion; the analog side scales it.
         trip_current_target_out <= step_ratio_in;
      end
   end

   // ------------------------------------------------------------
   // Protection latches, cleared only by power-on reset
   // ------------------------------------------------------------
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         short_fault_out   <= 1'b0;
         thermal_fault_out <= 1'b0;
         open_fault_out    <= 1'b0;
         open_event_out    <= 1'b0;
         open_run_ff       <= 2'h0;
         brk_time_ff       <= 16'h0000;
         seen_pos_ff       <= 1'b0;
      end else begin
         if (short_s)
            short_fault_out <= 1'b1;
         if (hot_s)
            thermal_fault_out <= 1'b1;
         open_event_out <= 1'b0;
         if (state_ff == S_OFF && pos_s) begin
            seen_pos_ff <= 1'b1;
            // Short surge pulses add little; only sustained breakdown gets past the window.
            if (brk_time_ff != 16'hFFFF)
               brk_time_ff <= brk_time_ff + 16'h0001;
         end
         if (off_exit) begin
            seen_pos_ff <= 1'b0;
            // The last off cycle still counts, so a detection there is not lost to the clear.
            if (seen_pos_ff || pos_s) begin
               open_event_out <= 1'b1;
               if (open_run_ff != C_OTRIP)
                  open_run_ff <= open_run_ff + 2'h1;
            end else begin
               open_run_ff <= 2'h0;
               brk_time_ff <= 16'h0000;
            end
         end
         if (open_run_ff == C_OTRIP && brk_time_ff > C_ODLY)
            open_fault_out <= 1'b1;
      end
   end
endmodule // scp_chopper

// [verilog/scp_map.vh]
// Purpose : Constants for the stepper chopper and protection block.
// Assumes : 50 MHz clock, one winding pair.
// Notes   : Times are given in nanoseconds; cycle counts derive from them.
`ifndef SCP_MAP_VH
`define SCP_MAP_VH
`define SCP_CLK_PERIOD_NS    20
// Off-time levels, selected by the step current ratio.
`define SCP_OFF_HIGH_NS      12000
`define SCP_OFF_MID_NS       8000
`define SCP_OFF_LOW_NS       4000
// Ratio bounds (of an 8-bit ratio) for off-time level choice.
`define SCP_RATIO_HIGH_MIN   8'hB4
`define SCP_RATIO_MID_MIN    8'h5A
`define SCP_DEAD_NS          500
`define SCP_BLANK_NS         1700
`define SCP_OPEN_TRIP_COUNT  2'h3
`define SCP_OPEN_DELAY_NS    2000
// Cycle counts; least times round up.
`define SCP_CYC_UP(ns)       (((ns) + `SCP_CLK_PERIOD_NS - 1) / `SCP_CLK_PERIOD_NS)
`define SCP_OFF_HIGH_CYC     `SCP_CYC_UP(`SCP_OFF_HIGH_NS)
`define SCP_OFF_MID_CYC      `SCP_CYC_UP(`SCP_OFF_MID_NS)
`define SCP_OFF_LOW_CYC      `SCP_CYC_UP(`SCP_OFF_LOW_NS)
`define SCP_DEAD_CYC         `SCP_CYC_UP(`SCP_DEAD_NS)
`define SCP_BLANK_CYC        `SCP_CYC_UP(`SCP_BLANK_NS)
`define SCP_OPEN_DELAY_CYC   `SCP_CYC_UP(`SCP_OPEN_DELAY_NS)
`endif

// [verilog/scp_sync2.v]
// Purpose : Two-flop synchroniser for a group of pin levels.
// Assumes : Inputs are asynchronous levels.
// Notes   : The first stage feeds only the second stage.
`timescale 1ns/1ps
module scp_sync2 #(
   parameter W = 1
) (
   input  wire         clk_in,
   input  wire         reset_in,
   input  wire [W-1:0] d_in,
   output wire [W-1:0] q_out
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= d_in;
         sync_ff <= meta_ff;
      end
   end
   assign q_out = sync_ff;
endmodule // scp_sync2

// [bench/scp_winding.sv]
// Purpose : Behavioural winding seen through the switches and sense resistor.
// Assumes : Current reaches the trip level a set number of on cycles after turn-on.
// Notes   : An open coil turns the sense voltage positive while the off switch conducts.
`timescale 1ns/1ps
module scp_winding (
   input  wire       clk_in,
   input  wire       drive_on_in,
   input  wire       rectify_on_in,
   input  wire       open_coil_in,
   input  wire [7:0] on_len_in,
   output reg        trip_cmp_out,
   output wire       sense_positive_out
);
   reg [7:0] on_cnt_ff = 8'h00;
   initial trip_cmp_out = 1'b0;
   always @(posedge clk_in) begin
      on_cnt_ff <= drive_on_in ? on_cnt_ff + 8'h01 : 8'h00;
      trip_cmp_out <= drive_on_in && (on_cnt_ff >= on_len_in);
   end
   assign sense_positive_out = open_coil_in & rectify_on_in;
endmodule // scp_winding

// [bench/scp_chopper_properties.sv]
// Purpose : Switch timing and protection properties at the chopper ports.
// Assumes : DEAD shortened to 3 cycles; blanking lasts at least 5 cycles.
// Notes   : Pin inputs pass two synchroniser flops, hence the short windows.
`timescale 1ns/1ps
module scp_chopper_properties #(
   parameter RW    = 8,
   parameter DEAD  = 3,
   parameter BLANK = 5
) (
   input wire          clk_in,
   input wire          reset_in,
   input wire          enable_in,
   input wire [RW-1:0] step_ratio_in,
   input wire          trip_cmp_in,
   input wire          short_cmp_in,
   input wire          sense_positive_in,
   input wire          thermal_shutdown_threshold_in,
   input wire          drive_on_out,
   input wire          rectify_on_out,
   input wire [RW-1:0] trip_current_target_out,
   input wire          short_fault_out,
   input wire          open_fault_out,
   input wire          thermal_fault_out,
   input wire          open_event_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   wire any_fault = short_fault_out | open_fault_out | thermal_fault_out;
   sequence s_dead;
      (!drive_on_out && !rectify_on_out) [*3];
   endsequence
   sequence s_blank;
      drive_on_out [*5];
   endsequence
   a_no_overlap: assert property (!(drive_on_out && rectify_on_out)) else $error("overlap");
   a_dead_on: assert property ($fell(drive_on_out) |-> s_dead) else $error("dead time");
   a_dead_off: assert property ($fell(rectify_on_out) |-> s_dead) else $error("dead time");
   a_blank_min: assert property ($rose(drive_on_out) |-> s_blank) else $error("blanking");
   a_short_trip: assert property (
      short_cmp_in |-> ##[1:4] (short_fault_out && !drive_on_out)) else $error("short not tripped");
   a_short_held: assert property (short_fault_out |=> short_fault_out) else $error("short lost");
   a_fault_quiet: assert property (
      any_fault |=> !drive_on_out && !rectify_on_out) else $error("fault drives");
   a_hot_trip: assert property (
      thermal_shutdown_threshold_in |-> ##[1:4] thermal_fault_out) else $error("thermal not tripped");
   a_open_held: assert property (open_fault_out |=> open_fault_out) else $error("open lost");
   a_target_copy: assert property (
      !$past(reset_in) |-> trip_current_target_out == $past(step_ratio_in)) else $error("target");
   a_event_pulse: assert property (open_event_out |=> !open_event_out) else $error("event");
endmodule // scp_chopper_properties
bind scp_chopper scp_chopper_properties #(.RW(RW), .DEAD(DEAD), .BLANK(BLANK)) u_props (
   .clk_in, .reset_in, .enable_in, .step_ratio_in, .trip_cmp_in, .short_cmp_in,
   .sense_positive_in, .thermal_shutdown_threshold_in, .drive_on_out, .rectify_on_out,
   .trip_current_target_out, .short_fault_out, .open_fault_out, .thermal_fault_out,
   .open_event_out);

// [bench/testbench.sv]
// Purpose : Self-checking bench for the chopper and its protection.
// Assumes : Off levels 12/8/4, DEAD 3, OPEN_DLY 4 cycles; blanking at its 85-cycle default.
// Notes   : Inputs change 2 ns after the rising edge.
`timescale 1ns/1ps
module testbench;
   reg        clk_in = 1'b0;
   reg        reset_in = 1'b1;
   reg        enable_in = 1'b0;
   reg  [7:0] ratio = 8'h00;
   reg        short_pin = 1'b0;
   reg        hot_pin = 1'b0;
   reg        open_coil = 1'b0;
   reg  [7:0] on_len = 8'h0A;
   wire       drive, rect, trip, sense, sf, of, tf, ev;
   wire [7:0] target;
   integer    n_mismatch = 0;
   integer    checks_done = 0;
   integer    cyc = 0;
   integer    nev = 0;
   integer    i, len, k, want;
   always #10 clk_in = ~clk_in;
   scp_chopper #(.OFF_HIGH(12), .OFF_MID(8), .OFF_LOW(4), .DEAD(3), .OPEN_DLY(4)) uut (
      .clk_in(clk_in), .reset_in(reset_in), .enable_in(enable_in), .step_ratio_in(ratio),
      .trip_cmp_in(trip), .short_cmp_in(short_pin), .sense_positive_in(sense),
      .thermal_shutdown_threshold_in(hot_pin), .drive_on_out(drive), .rectify_on_out(rect),
      .trip_current_target_out(target), .short_fault_out(sf), .open_fault_out(of),
      .thermal_fault_out(tf), .open_event_out(ev));
   scp_winding u_wind (.clk_in(clk_in), .drive_on_in(drive), .rectify_on_in(rect),
      .open_coil_in(open_coil), .on_len_in(on_len), .trip_cmp_out(trip),
      .sense_positive_out(sense));
   always @(posedge clk_in) begin
      cyc = cyc + 1;
      if (ev === 1'b1) nev = nev + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         results;
      end
   end
   task tick; begin @(posedge clk_in); #2; end endtask
   task check(input [7:0] seen, input [7:0] exp); begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   end endtask
   // Bounded wait until drive (sel 0) or rectify (sel 1) shows the given level.
   task wait_on(input sel, input lvl); begin
      k = 0;
      while (((sel ? rect : drive) !== lvl) && k < 200) begin tick; k = k + 1; end
   end endtask
   task do_reset; begin
      reset_in = 1'b1;
      repeat (3) tick;
      reset_in = 1'b0;
      tick;
      check({drive, rect, sf, of, tf, ev}, 8'h00);
   end endtask
   task t_levels; begin
      enable_in = 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         ratio = {8'hB4, 8'hB3, 8'h5A, 8'h59} >> (8 * (3 - i));
         wait_on(0, 1); wait_on(1, 1);
         len = 0;
         while (rect === 1'b1 && len < 100) begin tick; len = len + 1; end
         check(len, {8'h0C, 8'h08, 8'h08, 8'h04} >> (8 * (3 - i)));
         check(target, ratio);
      end
      $display("levels done");
   end endtask
   task t_blank; begin
      on_len = 8'h00;
      wait_on(1, 1); wait_on(0, 1);
      len = 0;
      while (drive === 1'b1 && len < 100) begin tick; len = len + 1; end
      check((len >= 85) && (len <= 88), 8'h01);
      on_len = 8'h0A;
      $display("blank done");
   end endtask
   task t_enable; begin
      wait_on(1, 1);
      enable_in = 1'b0;
      repeat (3) tick;
      check({drive, rect}, 8'h00);
      enable_in = 1'b1;
      wait_on(0, 1);
      check(drive, 8'h01);
      $display("enable done");
   end endtask
   task t_open; begin
      ratio = 8'h5A;
      want = 0;
      for (i = 0; i < 6; i = i + 1) begin
         wait_on(0, 1);
         open_coil = 6'b111011 >> i;
         want = want + open_coil;
         wait_on(1, 1); wait_on(1, 0);
         repeat (3) tick;
         check(nev, want);
         check(of, i == 5);
      end
      open_coil = 1'b0;
      repeat (30) tick;
      check({of, drive, rect}, 8'h04);
      $display("open done");
   end endtask
   task t_fault(input which); begin
      do_reset;
      wait_on(1, 1);
      if (which) hot_pin = 1'b1; else short_pin = 1'b1;
      tick;
      hot_pin = 1'b0;
      short_pin = 1'b0;
      repeat (5) tick;
      check({sf, tf, drive, rect}, which ? 8'h04 : 8'h08);
      repeat (30) tick;
      check({sf, tf, drive, rect}, which ? 8'h04 : 8'h08);
      $display("fault done");
   end endtask
   task results; begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end endtask
   initial begin
      do_reset;
      t_levels;
      t_blank;
      t_enable;
      t_open;
      t_fault(1'b0);
      t_fault(1'b1);
      do_reset;
      results;
   end
endmodule // testbench
